/* File: rtl/edi_pkg.sv */
// Summary of operation
// - exception taken reads dispatch base register
// - exception number indexes table, fetch handler
// - low entries core traps, high peripherals
// - taking exception clears global enable
// - writing global enable one allows interrupts
// - accept maskable only when both enables
// - reset: local enable one, global zero
// - disable/enable instructions touch local only
// - after local enable, global decides acceptance
// - handler masks sources, then sets global
// - non-maskable bypasses both enables
package edi_pkg;
    // register offsets on the plain port (byte offsets, matched against regAddr unscaled)
    localparam logic [3:0] REG_DISPATCH_BASE = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_HANDLER = 4'h8;
    localparam logic [3:0] REG_EXC_NUM = 4'hc;
    // status register fields
    localparam int STAT_GLOBAL_BIT = 0;
    localparam int STAT_LOCAL_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;
    localparam logic STAT_GLOBAL_RST = 1'b0;
    localparam logic STAT_LOCAL_RST = 1'b1;
    // exception numbers of the core-common region
    localparam logic [7:0] EXC_NMI = 8'h01;
    localparam logic [7:0] EXC_SVC = 8'h05;
    localparam logic [7:0] EXC_DVZ = 8'h06;
    localparam logic [7:0] EXC_FLG = 8'h07;
    localparam logic [7:0] EXC_BPT = 8'h08;
    localparam logic [7:0] EXC_TRC = 8'h09;
    localparam logic [7:0] EXC_UND = 8'h0a;
    localparam logic [7:0] EXC_ISE = 8'h0f;
    // first number of the peripheral region
    localparam logic [7:0] EXC_PERIPH_BASE = 8'h10;
    // bytes per table entry, as a shift
    localparam int ENTRY_SHIFT = 2;
    // instruction-side commands
    typedef enum logic [1:0] {
        EDI_CMD_NONE = 2'h0,
        EDI_CMD_LOCAL_DISABLE = 2'h1,
        EDI_CMD_LOCAL_ENABLE = 2'h2
    } edi_cmd_type;
endpackage

/* File: rtl/edi_exception_dispatch.sv */
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module edi_exception_dispatch
    import edi_pkg::*;
#(
    parameter int AW = 32
) (
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // instruction side
    input wire logic localDisableInstr,
    input wire logic localEnableInstr,
    input wire logic trapReq,
    input wire logic [3:0] trapNum,
    input wire logic nmiReq,
    // irq control unit side
    input wire logic irqTrigger,
    input wire logic [3:0] irqNum,
    // memory fetch of the table entry
    output logic memRd,
    output logic [AW-1:0] memAddr,
    input wire logic memValid,
    input wire logic [AW-1:0] memRdata,
    // redirect of execution
    output logic jumpValid,
    output logic [AW-1:0] jumpAddr,
    output logic irqAck,
    output logic globalEnable,
    output logic localEnable
);
    // one-hot sequencer state
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FETCH = 3'b010,
        ST_JUMP = 3'b100
    } edi_state_type;

    // every register of the block, all cleared or preset by rst
    edi_state_type state_ff;
    logic [AW-1:0] base_ff;
    logic [7:0] excNum_ff;
    logic [AW-1:0] handler_ff;
    logic global_ff;
    logic local_ff;
    logic memRd_ff;
    logic [AW-1:0] memAddr_ff;
    logic jumpValid_ff;
    logic irqAck_ff;
    logic [31:0] regRdata_ff;

    // entry address from base and number
    function automatic logic [AW-1:0] entry_addr(input logic [AW-1:0] b,
                                                 input logic [7:0] n);
        entry_addr = b + (AW'(n) << ENTRY_SHIFT);
    endfunction

    // one address decode shared by the register writes
    function automatic logic reg_hit(input logic strobe,
                                     input logic [3:0] addr,
                                     input logic [3:0] offset);
        reg_hit = strobe && (addr == offset);
    endfunction

    // status word from the field positions, spare bits read zero
    function automatic logic [31:0] status_word(input logic busy,
                                                input logic loc,
                                                input logic glb);
        status_word = 32'h0;
        status_word[STAT_BUSY_BIT] = busy;
        status_word[STAT_LOCAL_BIT] = loc;
        status_word[STAT_GLOBAL_BIT] = glb;
    endfunction

    // write decodes; reads never change state
    logic statusWr;
    logic baseWr;
    assign statusWr = reg_hit(regWr, regAddr, REG_STATUS);
    assign baseWr = reg_hit(regWr, regAddr, REG_DISPATCH_BASE);

    // maskable requests need both enables; nmi and traps are not masked
    logic maskOk;
    logic takeNmi;
    logic takeTrap;
    logic takeIrq;
    logic takeAny;
    logic [7:0] nxt_excNum;
    assign maskOk = global_ff & local_ff;
    assign takeNmi = (state_ff == ST_IDLE) & nmiReq;
    assign takeTrap = (state_ff == ST_IDLE) & ~nmiReq & trapReq;
    assign takeIrq = (state_ff == ST_IDLE) & ~nmiReq & ~trapReq
                     & irqTrigger & maskOk;
    assign takeAny = takeNmi | takeTrap | takeIrq;

    // priority: nmi, then traps, then peripheral interrupts
    always_comb begin
        if (nmiReq) begin
            nxt_excNum = EXC_NMI;
        end else if (trapReq) begin
            nxt_excNum = {4'h0, trapNum};
        end else begin
            nxt_excNum = EXC_PERIPH_BASE | {4'h0, irqNum};
        end
    end

    // dispatch sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= ST_IDLE;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (takeAny) begin
                        state_ff <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    if (memValid) begin
                        state_ff <= ST_JUMP;
                    end
                end
                ST_JUMP: begin
                    state_ff <= ST_IDLE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // capture number and drive the table read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            excNum_ff <= 8'h00;
            memRd_ff <= 1'b0;
            memAddr_ff <= '0;
        end else begin
            if (takeAny) begin
                excNum_ff <= nxt_excNum;
                memRd_ff <= 1'b1;
                memAddr_ff <= entry_addr(base_ff, nxt_excNum);
            end else if (state_ff == ST_FETCH && memValid) begin
                memRd_ff <= 1'b0;
            end
        end
    end

    // fetched entry becomes the new program address
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            handler_ff <= '0;
            jumpValid_ff <= 1'b0;
        end else begin
            jumpValid_ff <= (state_ff == ST_FETCH) & memValid;
            if (state_ff == ST_FETCH && memValid) begin
                handler_ff <= memRdata;
            end
        end
    end

    // acknowledge toward the control unit when its request is taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqAck_ff <= 1'b0;
        end else begin
            irqAck_ff <= takeIrq;
        end
    end

    // global enable: cleared on entry, software write sets it
    // entry wins over a same-cycle write so a handler starts masked
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            global_ff <= STAT_GLOBAL_RST;
        end else if (takeAny) begin
            global_ff <= 1'b0;
        end else if (statusWr) begin
            global_ff <= regWdata[STAT_GLOBAL_BIT];
        end
    end

    // local enable: only the two dedicated instructions and writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            local_ff <= STAT_LOCAL_RST;
        end else if (localDisableInstr) begin
            local_ff <= 1'b0;
        end else if (localEnableInstr) begin
            local_ff <= 1'b1;
        end else if (statusWr) begin
            local_ff <= regWdata[STAT_LOCAL_BIT];
        end
    end

    // dispatch base register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            base_ff <= '0;
        end else if (baseWr) begin
            base_ff <= regWdata[AW-1:0];
        end
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdata_ff <= 32'h0;
        end else if (regRd) begin
            unique case (regAddr)
                REG_DISPATCH_BASE: regRdata_ff <= 32'(base_ff);
                REG_STATUS: regRdata_ff <= status_word(state_ff != ST_IDLE,
                                                       local_ff, global_ff);
                REG_HANDLER: regRdata_ff <= 32'(handler_ff);
                REG_EXC_NUM: regRdata_ff <= {24'h0, excNum_ff};
                default: regRdata_ff <= 32'h0;
            endcase
        end else begin
            regRdata_ff <= 32'h0;
        end
    end

    // outputs straight from flops, so no glitch reaches the core
    assign regRdata = regRdata_ff;
    assign memRd = memRd_ff;
    assign memAddr = memAddr_ff;
    assign jumpValid = jumpValid_ff;
    assign jumpAddr = handler_ff;
    assign irqAck = irqAck_ff;
    assign globalEnable = global_ff;
    assign localEnable = local_ff;

    // maskable interrupt never taken with an enable low
    chk_mask_gate: assert property (@(posedge clk) disable iff (rst)
        (irqAck && !$past(nmiReq) && !$past(trapReq))
            |-> $past(global_ff) && $past(local_ff))
        else $error("maskable interrupt taken while disabled");
    // entry clears global enable next cycle
    chk_entry_clear: assert property (@(posedge clk) disable iff (rst)
        takeAny |=> !global_ff)
        else $error("global enable not cleared on entry");
    // nmi taken regardless of enables
    chk_nmi_ungated: assert property (@(posedge clk) disable iff (rst)
        (state_ff == ST_IDLE && nmiReq)
            |=> memRd && excNum_ff == EXC_NMI)
        else $error("nmi not dispatched");
    // fetch address is base plus scaled number
    chk_fetch_addr: assert property (@(posedge clk) disable iff (rst)
        takeAny |=> memAddr ==
            $past(base_ff) + (AW'($past(nxt_excNum)) << ENTRY_SHIFT))
        else $error("wrong table entry address");
    // fetched entry appears as jump target
    chk_jump_data: assert property (@(posedge clk) disable iff (rst)
        (state_ff == ST_FETCH && memValid)
            |=> jumpValid && jumpAddr == $past(memRdata))
        else $error("jump address differs from fetched entry");
    // local instructions leave global untouched
    chk_local_only: assert property (@(posedge clk) disable iff (rst)
        ((localDisableInstr || localEnableInstr) && !takeAny
            && !(regWr && regAddr == REG_STATUS))
            |=> $stable(global_ff))
        else $error("local instruction altered global enable");
    // local enable sets the bit when no local disable comes with it
    chk_local_set: assert property (@(posedge clk) disable iff (rst)
        localEnableInstr && !localDisableInstr |=> local_ff)
        else $error("local enable did not set bit");
    // software write of one sets global enable
    chk_global_write: assert property (@(posedge clk) disable iff (rst)
        (regWr && regAddr == REG_STATUS && regWdata[STAT_GLOBAL_BIT]
            && !takeAny) |=> global_ff)
        else $error("global enable write lost");
    // base register seen in the fetch
    chk_base_used: assert property (@(posedge clk) disable iff (rst)
        (takeAny && nxt_excNum == 8'h00) |=> memAddr == $past(base_ff))
        else $error("dispatch base not used");

    // local disable always clears the bit
    chk_local_clear: assert property (@(posedge clk) disable iff (rst)
        localDisableInstr |=> !local_ff)
        else $error("local disable did not clear bit");
    // acknowledge lasts one cycle so the control unit sees one take
    chk_ack_pulse: assert property (@(posedge clk) disable iff (rst)
        irqAck |=> !irqAck)
        else $error("acknowledge longer than one cycle");
    // peripheral number lands in the upper region of the table
    chk_irq_number: assert property (@(posedge clk) disable iff (rst)
        takeIrq |=> excNum_ff ==
            (EXC_PERIPH_BASE | {4'h0, $past(irqNum)}))
        else $error("peripheral number not in upper region");
    // trap numbers stay in the core-common region
    chk_trap_number: assert property (@(posedge clk) disable iff (rst)
        takeTrap |=> excNum_ff == {4'h0, $past(trapNum)})
        else $error("trap number not in lower region");
    // a low enable holds maskable requests off
    chk_held_off: assert property (@(posedge clk) disable iff (rst)
        (!global_ff || !local_ff) |=> !irqAck)
        else $error("maskable request taken while held off");
    // local enable with global low keeps interrupts off
    chk_restore_off: assert property (@(posedge clk) disable iff (rst)
        (localEnableInstr && !global_ff && !statusWr) |=> !maskOk)
        else $error("local enable opened a globally closed gate");
    // local enable with global high reopens the gate
    chk_restore_on: assert property (@(posedge clk) disable iff (rst)
        (localEnableInstr && !localDisableInstr && global_ff && !takeAny
            && !statusWr) |=> maskOk)
        else $error("local enable did not restore acceptance");
    // the table read stands with a fixed address until answered
    chk_fetch_hold: assert property (@(posedge clk) disable iff (rst)
        (memRd && !memValid) |=> memRd && $stable(memAddr))
        else $error("table read dropped or moved before answer");
    // one redirect per fetched entry
    chk_jump_pulse: assert property (@(posedge clk) disable iff (rst)
        jumpValid |=> !jumpValid)
        else $error("redirect longer than one cycle");
    // global enable moves only on entry or a status write
    chk_global_hold: assert property (@(posedge clk) disable iff (rst)
        (!takeAny && !statusWr) |=> $stable(global_ff))
        else $error("global enable changed without cause");
    // a trap beats a peripheral request in the same cycle
    chk_trap_first: assert property (@(posedge clk) disable iff (rst)
        (state_ff == ST_IDLE && trapReq && !nmiReq) |=> !irqAck)
        else $error("peripheral request beat a trap");
    // no table read without a taken exception
    chk_idle_quiet: assert property (@(posedge clk) disable iff (rst)
        (state_ff == ST_IDLE && !takeAny) |=> !memRd)
        else $error("table read without exception");
    // the base register keeps what software wrote
    chk_base_write: assert property (@(posedge clk) disable iff (rst)
        baseWr |=> base_ff == AW'($past(regWdata)))
        else $error("dispatch base write lost");
    // read data stands one cycle only and idles at zero
    chk_read_idle: assert property (@(posedge clk) disable iff (rst)
        !regRd |=> regRdata == 32'h0)
        else $error("read data left standing");
    // handler address holds until the next fetch answers
    chk_handler_hold: assert property (@(posedge clk) disable iff (rst)
        !(state_ff == ST_FETCH && memValid) |=> $stable(jumpAddr))
        else $error("handler address changed without fetch");
    // a non-maskable request beats traps in the same cycle
    chk_nmi_first: assert property (@(posedge clk) disable iff (rst)
        takeNmi |=> excNum_ff == EXC_NMI && !irqAck)
        else $error("non-maskable request lost its priority");
endmodule // edi_exception_dispatch

/* File: tb/edi_irq_ctrl_model.sv */
`timescale 1ns/1ps
module edi_irq_ctrl_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] srcReq,
    input wire logic [15:0] srcMask,
    output logic irqTrigger,
    output logic [3:0] irqNum
);
    logic [15:0] pend;
    logic [3:0] lowNum;
    logic [3:0] lastNum;
    // masked sources never reach the core
    always_comb pend = srcReq & ~srcMask;
    // lowest pending source wins
    always_comb begin
        lowNum = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (pend[i]) begin
                lowNum = 4'(i);
            end
        end
    end
    // number idles inverted, never stale
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqTrigger <= 1'b0;
            irqNum <= 4'hf;
            lastNum <= 4'h0;
        end else begin
            irqTrigger <= |pend;
            if (|pend) begin
                irqNum <= lowNum;
                lastNum <= lowNum;
            end else begin
                irqNum <= ~lastNum;
            end
        end
    end
endmodule // edi_irq_ctrl_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
    import edi_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    logic dis = 1'b0;
    logic ena = 1'b0;
    logic trapReq = 1'b0;
    logic [3:0] trapNum = 4'h0;
    logic nmiReq = 1'b0;
    logic irqTrigger;
    logic [3:0] irqNum;
    logic memRd;
    logic [31:0] memAddr;
    logic memValid = 1'b0;
    logic [31:0] memRdata = 32'h0;
    logic jumpValid;
    logic [31:0] jumpAddr;
    logic irqAck;
    logic globalEnable;
    logic localEnable;
    logic [15:0] srcReq = 16'h0;
    logic [15:0] srcMask = 16'h0;
    int numErrors = 0;
    int compares = 0;
    int cycles = 0;
    localparam logic [31:0] BASE = 32'h0000_1000;

    always #5 clk = ~clk;

    edi_exception_dispatch #(.AW(32)) i_dut (.clk(clk), .rst(rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .localDisableInstr(dis),
        .localEnableInstr(ena), .trapReq(trapReq), .trapNum(trapNum),
        .nmiReq(nmiReq), .irqTrigger(irqTrigger), .irqNum(irqNum),
        .memRd(memRd), .memAddr(memAddr), .memValid(memValid),
        .memRdata(memRdata), .jumpValid(jumpValid), .jumpAddr(jumpAddr),
        .irqAck(irqAck), .globalEnable(globalEnable),
        .localEnable(localEnable));
    edi_irq_ctrl_model i_irqCtrl (.clk(clk), .rst(rst), .srcReq(srcReq),
        .srcMask(srcMask), .irqTrigger(irqTrigger), .irqNum(irqNum));

    task automatic wrap_up;
        $display("errors=%0d compares=%0d", numErrors, compares);
        if (numErrors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            numErrors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 check(regRdata, exp);
    endtask
    // serve one table fetch; requests drop once the fetch starts
    task automatic take(input logic [7:0] n, input int dly, input logic ack);
        int i;
        for (i = 0; i < 20 && memRd !== 1'b1; i++) @(posedge clk) #1;
        check(memAddr, BASE + ({24'h0, n} << ENTRY_SHIFT));
        check(irqAck, ack);
        @(posedge clk);
        nmiReq <= 1'b0;
        trapReq <= 1'b0;
        srcReq <= 16'h0;
        repeat (dly) @(posedge clk);
        memValid <= 1'b1;
        memRdata <= ~memAddr;
        @(posedge clk);
        memValid <= 1'b0;
        #1 check({jumpValid, jumpAddr}, {1'b1, ~memAddr});
        check(globalEnable, 1'b0);
    endtask
    task automatic no_take(input int n);
        repeat (n) @(posedge clk) #1 check(memRd, 1'b0);
    endtask
    task automatic instr(input logic d, input logic [1:0] exp);
        @(posedge clk);
        dis <= d;
        ena <= ~d;
        @(posedge clk);
        dis <= 1'b0;
        ena <= 1'b0;
        #1 check({localEnable, globalEnable}, exp);
    endtask

    task automatic t_reset;
        check({localEnable, globalEnable}, 2'h2);
        rd(REG_STATUS, 32'h2);
        rd(4'h2, 32'h0);
        wr(REG_DISPATCH_BASE, BASE);
        rd(REG_DISPATCH_BASE, BASE);
    endtask
    task automatic t_nmi_traps;
        logic [7:0] codes [8] = '{EXC_SVC, EXC_DVZ, EXC_FLG, EXC_BPT,
            EXC_TRC, EXC_UND, EXC_ISE, 8'h00};
        @(posedge clk);
        nmiReq <= 1'b1;
        take(EXC_NMI, 3, 1'b0);
        foreach (codes[k]) begin
            wr(REG_STATUS, 32'h3);
            trapNum <= codes[k][3:0];
            trapReq <= 1'b1;
            take(codes[k], k, 1'b0);
            rd(REG_EXC_NUM, {24'h0, codes[k]});
        end
    endtask
    task automatic t_gate;
        srcReq <= 16'h0020;
        no_take(5);
        wr(REG_STATUS, 32'h3);
        take(EXC_PERIPH_BASE | 8'h05, 1, 1'b1);
        wr(REG_STATUS, 32'h3);
        instr(1'b1, 2'h1);
        srcReq <= 16'h0100;
        no_take(5);
        instr(1'b0, 2'h3);
        take(EXC_PERIPH_BASE | 8'h08, 0, 1'b1);
        srcReq <= 16'h0100;
        instr(1'b1, 2'h0);
        instr(1'b0, 2'h2);
        no_take(5);
        srcReq <= 16'h0;
    endtask
    task automatic t_mask;
        srcMask <= 16'h0008;
        srcReq <= 16'h0028;
        wr(REG_STATUS, 32'h3);
        take(EXC_PERIPH_BASE | 8'h05, 2, 1'b1);
        rd(REG_HANDLER, ~(BASE + (32'h15 << ENTRY_SHIFT)));
    endtask

    // bounded run; a hang counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            numErrors++;
            wrap_up();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_nmi_traps();
        t_gate();
        t_mask();
        wrap_up();
    end
endmodule // tb
